// ==== include/adc_map.svh ====
// Register addresses, field positions, reset values and timing counts of the converter
`ifndef ADC_MAP_SVH
`define ADC_MAP_SVH

`define ADC_ADDR_RES_A_HIGH 20'hFFFE0
`define ADC_ADDR_RES_A_LOW 20'hFFFE1
`define ADC_ADDR_RES_B_HIGH 20'hFFFE2
`define ADC_ADDR_RES_B_LOW 20'hFFFE3
`define ADC_ADDR_RES_C_HIGH 20'hFFFE4
`define ADC_ADDR_RES_C_LOW 20'hFFFE5
`define ADC_ADDR_RES_D_HIGH 20'hFFFE6
`define ADC_ADDR_RES_D_LOW 20'hFFFE7
`define ADC_ADDR_CONTROL_STATUS 20'hFFFE8
`define ADC_ADDR_TRIGGER_CONTROL 20'hFFFE9

`define ADC_BIT_DONE_FLAG 7
`define ADC_BIT_IRQ_ENABLE 6
`define ADC_BIT_GO 5
`define ADC_BIT_SCAN 4
`define ADC_BIT_TIME_SELECT 3
`define ADC_BIT_GROUP 2
`define ADC_BIT_TRIGGER_ENABLE 7
`define ADC_BIT_TRG_SPARE 0

`define ADC_RESET_CONTROL_STATUS 8'h00
`define ADC_RESET_TRIGGER_CONTROL 8'h7E
`define ADC_TRG_FIXED_ONES 8'h7E
`define ADC_RESET_RESULT 10'h000

`define ADC_STATES_FIRST_SLOW 8'd134
`define ADC_STATES_FIRST_FAST 8'd70
`define ADC_STATES_NEXT_SLOW 8'd128
`define ADC_STATES_NEXT_FAST 8'd66

`endif

// ==== include/adc_pkg.sv ====
// Types shared by the converter control modules
package adc_pkg;

   typedef enum logic {
      SEQ_IDLE,
      SEQ_CONVERT
   } seq_state_type;

   typedef logic [9:0] sample_type;

endpackage

// ==== include/conv_if.sv ====
// Signals between the sequencer, its conversion timer and its result store
`timescale 1ns/100ps
`default_nettype none

interface conv_if;
   import adc_pkg::*;
   // Timer control
   logic start;
   logic cancel;
   logic fast;
   logic first;
   logic done;
   // Result store
   logic clear;
   logic write;
   logic [1:0] write_index;
   sample_type write_data;
   logic read_high;
   logic read_low;
   logic [1:0] read_index;
   logic [7:0] read_data;

   modport ctrl (
      output start, cancel, fast, first, clear, write, write_index, write_data, read_high, read_low, read_index,
      input done, read_data
   );
   modport timer (
      input start, cancel, fast, first, clear,
      output done
   );
   modport store (
      input clear, write, write_index, write_data, read_high, read_low, read_index,
      output read_data
   );
endinterface

`default_nettype wire

// ==== src/conv_timer.sv ====
// Counts the states of one conversion and pulses done at its end
`timescale 1ns/100ps
`default_nettype none
`include "adc_map.svh"

module conv_timer
   import adc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Sequencer side
   conv_if.timer link
);

   typedef struct packed {
      logic busy;
      logic [7:0] count;
      logic done;
   } timer_state_type;

   timer_state_type st_reg, st_next;

   assign link.done = st_reg.done;

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (link.clear || link.cancel) begin
         st_next.busy = 1'b0;
         st_next.count = 8'h00;
      end else if (link.start) begin
         st_next.busy = 1'b1;
         if (link.first) begin
            st_next.count = link.fast ? `ADC_STATES_FIRST_FAST - 8'd1 : `ADC_STATES_FIRST_SLOW - 8'd1;
         end else begin
            st_next.count = link.fast ? `ADC_STATES_NEXT_FAST - 8'd1 : `ADC_STATES_NEXT_SLOW - 8'd1;
         end
      end else if (st_reg.busy) begin
         if (st_reg.count == 8'h01) begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end
         st_next.count = st_reg.count - 8'd1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

endmodule

`default_nettype wire

// ==== src/result_store.sv ====
// Four conversion results and the low-byte holding latch
`timescale 1ns/100ps
`default_nettype none
`include "adc_map.svh"

module result_store
   import adc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Sequencer side
   conv_if.store link
);

   typedef struct packed {
      logic [3:0][9:0] result;
      logic [7:0] low_latch;
   } store_state_type;

   store_state_type st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      link.read_data = 8'h00;
      if (link.read_high) begin
         // upper eight bits in the high byte
         link.read_data = st_reg.result[link.read_index][9:2];
         // capture the low byte on a high read
         st_next.low_latch = {st_reg.result[link.read_index][1:0], 6'b000000};
      end else if (link.read_low) begin
         // low byte comes from the latch
         link.read_data = st_reg.low_latch;
      end
      if (link.write) begin
         st_next.result[link.write_index] = link.write_data;
      end
      if (link.clear) begin
         st_next.result = {4{`ADC_RESET_RESULT}};
         st_next.low_latch = 8'h00;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

endmodule

`default_nettype wire

// ==== src/adc_sequencer.sv ====
// Converter sequencer: register file, start sources, channel rotation, flags and requests
//
// Summary of operation
// - result top eight bits high, two low
// - result bits five to zero read zero
// - group inputs one to four to A-D
// - results cleared by reset and standby
// - control/status cleared by reset and standby
// - done flag on single end or scan pass
// - DMA activation also clears done flag
// - interrupt while flag set and enabled
// - go bit set by software or triggers
// - single mode clears go after conversion
// - scan repeats until go cleared
// - bit four picks single or scan
// - bit three picks conversion time
// - single mode channel bits index eight inputs
// - scan top bit group, low bits count
// - DMA request follows interrupt, flag set and enabled
// - low byte read through holding latch
// - high read loads latch, read high first
// - trigger enable gates pin and timer starts
// - scan restarts group, advances immediately
`timescale 1ns/100ps
`default_nettype none
`include "adc_map.svh"

module adc_sequencer
   import adc_pkg::*;
(
   // Clock, reset, clock enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Low-power entry, clears as reset does
   input wire logic standby,
   // Peripheral bus
   input wire logic [19:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   // Start sources
   input wire logic external_trigger_pin,
   input wire logic timer_compare_match,
   // Analog front end
   input wire sample_type analog_result,
   output logic [2:0] analog_channel,
   output logic sample_start,
   // Requests
   output logic conversion_done_irq,
   output logic dma_request,
   input wire logic dma_ack
);

   typedef struct packed {
      seq_state_type seq;
      logic conversion_done_flag;
      logic done_irq_enable;
      logic conversion_go_bit;
      logic scan_mode;
      logic conversion_time_select;
      logic group_select_bit;
      logic channel_select_bit1;
      logic channel_select_bit0;
      logic trigger_enable_bit;
      logic trg_spare;
      logic flag_read_one;
      logic trigger_prev;
      logic [1:0] scan_index;
      logic [2:0] channel;
      logic sample_start;
      logic irq;
      logic dma;
      logic [7:0] rdata;
   } seq_reg_type;

   seq_reg_type st_reg, st_next;

   localparam logic [7:0] trg_reset_value = `ADC_RESET_TRIGGER_CONTROL;

   conv_if link ();

   conv_timer timer_inst (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .link(link.timer)
   );

   result_store store_inst (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .link(link.store)
   );

   assign bus_rdata = st_reg.rdata;
   assign analog_channel = st_reg.channel;
   assign sample_start = st_reg.sample_start;
   assign conversion_done_irq = st_reg.irq;
   assign dma_request = st_reg.dma;

   // Input picked for a conversion step, from mode, channel bits and scan position
   function automatic logic [2:0] pick_channel(input logic scan, input logic [2:0] sel, input logic [1:0] idx);
      logic [2:0] ch;
      ch = sel;
      if (scan) begin
         ch = {sel[2], idx};
      end
      return ch;
   endfunction

   // Result register index for an input
   function automatic logic [1:0] result_slot(input logic [2:0] ch);
      return ch[1:0];
   endfunction

   // Address decode of the peripheral bus
   logic sel_csr;
   logic sel_trg;
   logic sel_result;
   logic result_low;
   logic [1:0] result_index;
   logic [2:0] ch_sel;
   logic [19:0] result_off;

   always_comb begin
      sel_csr = bus_addr == `ADC_ADDR_CONTROL_STATUS;
      sel_trg = bus_addr == `ADC_ADDR_TRIGGER_CONTROL;
      sel_result = bus_addr >= `ADC_ADDR_RES_A_HIGH && bus_addr <= `ADC_ADDR_RES_D_LOW;
      result_off = bus_addr - `ADC_ADDR_RES_A_HIGH;
      result_low = result_off[0];
      result_index = result_off[2:1];
   end

   logic go_written_one;
   logic trigger_start;
   logic begin_conv;
   logic set_flag;
   logic [2:0] next_ch;

   always_comb begin
      st_next = st_reg;
      st_next.sample_start = 1'b0;
      go_written_one = 1'b0;
      trigger_start = 1'b0;
      begin_conv = 1'b0;
      set_flag = 1'b0;
      next_ch = st_reg.channel;
      ch_sel = {st_reg.group_select_bit, st_reg.channel_select_bit1, st_reg.channel_select_bit0};

      link.start = 1'b0;
      link.cancel = 1'b0;
      link.fast = st_reg.conversion_time_select;
      link.first = 1'b0;
      link.clear = standby;
      link.write = 1'b0;
      link.write_index = 2'b00;
      link.write_data = analog_result;
      link.read_high = bus_rd && sel_result && !result_low;
      link.read_low = bus_rd && sel_result && result_low;
      link.read_index = result_index;

      // Read data, taken one cycle after the strobe
      st_next.rdata = 8'h00;
      if (bus_rd) begin
         if (sel_csr) begin
            st_next.rdata = {st_reg.conversion_done_flag, st_reg.done_irq_enable, st_reg.conversion_go_bit,
                             st_reg.scan_mode, st_reg.conversion_time_select, ch_sel};
            // remember the flag was seen set
            if (st_reg.conversion_done_flag) begin
               st_next.flag_read_one = 1'b1;
            end
         end else if (sel_trg) begin
            st_next.rdata = {st_reg.trigger_enable_bit, 6'b000000, st_reg.trg_spare} | `ADC_TRG_FIXED_ONES;
         end else if (sel_result) begin
            // high read gives bits nine to two, low read has its low six bits zero
            st_next.rdata = link.read_data;
         end
      end

      // Register writes
      if (bus_wr && sel_csr) begin
         // only a zero after reading one clears
         if (!bus_wdata[`ADC_BIT_DONE_FLAG] && st_reg.flag_read_one) begin
            st_next.conversion_done_flag = 1'b0;
            st_next.flag_read_one = 1'b0;
         end
         st_next.done_irq_enable = bus_wdata[`ADC_BIT_IRQ_ENABLE];
         st_next.conversion_go_bit = bus_wdata[`ADC_BIT_GO];
         go_written_one = bus_wdata[`ADC_BIT_GO];
         st_next.scan_mode = bus_wdata[`ADC_BIT_SCAN];
         st_next.conversion_time_select = bus_wdata[`ADC_BIT_TIME_SELECT];
         st_next.group_select_bit = bus_wdata[`ADC_BIT_GROUP];
         st_next.channel_select_bit1 = bus_wdata[1];
         st_next.channel_select_bit0 = bus_wdata[0];
      end
      if (bus_wr && sel_trg) begin
         st_next.trigger_enable_bit = bus_wdata[`ADC_BIT_TRIGGER_ENABLE];
         st_next.trg_spare = bus_wdata[`ADC_BIT_TRG_SPARE];
      end

      if (dma_ack) begin
         st_next.conversion_done_flag = 1'b0;
         st_next.flag_read_one = 1'b0;
      end

      // falling pin edge or compare match
      st_next.trigger_prev = external_trigger_pin;
      trigger_start = st_reg.trigger_enable_bit &&
                      ((st_reg.trigger_prev && !external_trigger_pin) || timer_compare_match);
      // go bit set by hardware start
      if (trigger_start) begin
         st_next.conversion_go_bit = 1'b1;
      end

      unique case (st_reg.seq)
         SEQ_IDLE: begin
            begin_conv = st_next.conversion_go_bit;
         end
         SEQ_CONVERT: begin
            if (!st_next.conversion_go_bit) begin
               // abort, no result and no flag
               link.cancel = 1'b1;
               st_next.seq = SEQ_IDLE;
            end else if (link.done) begin
               link.write = 1'b1;
               link.write_index = result_slot(st_reg.channel);
               if (!st_reg.scan_mode) begin
                  // single conversion ends the go bit
                  set_flag = 1'b1;
                  st_next.conversion_go_bit = 1'b0;
                  st_next.seq = SEQ_IDLE;
               end else begin
                  if (st_reg.scan_index == {st_reg.channel_select_bit1, st_reg.channel_select_bit0}) begin
                     set_flag = 1'b1;
                     st_next.scan_index = 2'b00;
                  end else begin
                     st_next.scan_index = st_reg.scan_index + 2'd1;
                  end
                  next_ch = pick_channel(1'b1, ch_sel, st_next.scan_index);
                  st_next.channel = next_ch;
                  link.start = 1'b1;
                  st_next.sample_start = 1'b1;
               end
            end
         end
      endcase

      if (begin_conv) begin
         // single mode index of eight inputs
         // scan starts at the group's first input
         st_next.scan_index = 2'b00;
         next_ch = pick_channel(st_next.scan_mode, st_next.group_select_bit ?
                                {1'b1, st_next.channel_select_bit1, st_next.channel_select_bit0} :
                                {1'b0, st_next.channel_select_bit1, st_next.channel_select_bit0}, 2'b00);
         st_next.channel = next_ch;
         link.start = 1'b1;
         link.first = 1'b1;
         link.fast = st_next.conversion_time_select;
         st_next.sample_start = 1'b1;
         st_next.seq = SEQ_CONVERT;
      end

      // done flag, set wins over clear
      if (set_flag) begin
         st_next.conversion_done_flag = 1'b1;
      end

      st_next.irq = st_next.conversion_done_flag && st_next.done_irq_enable;
      // DMA request from the same event
      st_next.dma = st_next.irq;

      if (standby) begin
         st_next = '0;
         st_next.seq = SEQ_IDLE;
         st_next.trigger_enable_bit = trg_reset_value[`ADC_BIT_TRIGGER_ENABLE];
         st_next.trg_spare = 1'b0;
         st_next.trigger_prev = external_trigger_pin;
         link.cancel = 1'b1;
         link.start = 1'b0;
         link.write = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.seq <= SEQ_IDLE;
         st_reg.trigger_prev <= 1'b1;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

endmodule

`default_nettype wire

// ==== verif/adc_sequencer_properties.sv ====
// Port-level timing and value properties of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adc_map.svh"

module adc_sequencer_properties (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic standby,
   // Peripheral bus
   input wire logic [19:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   // Converter outputs and requests
   input wire logic sample_start,
   input wire logic conversion_done_irq,
   input wire logic dma_request,
   input wire logic dma_ack
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Single-mode start with interrupt enabled and no pending request
   sequence s_go_write(logic [3:0] f);
      bus_wr && bus_addr == `ADC_ADDR_CONTROL_STATUS && bus_wdata[6:3] == f && !conversion_done_irq;
   endsequence
   sequence s_fast_end;
      ##70 !conversion_done_irq ##[1:2] conversion_done_irq;
   endsequence
   sequence s_slow_end;
      ##134 !conversion_done_irq ##[1:2] conversion_done_irq;
   endsequence

   a_fast_done_time: assert property (s_go_write(4'b1101) |-> s_fast_end)
      else $error("fast conversion end out of time");
   a_slow_done_time: assert property (s_go_write(4'b1100) |-> s_slow_end)
      else $error("slow conversion end out of time");
   a_dma_follows_irq: assert property (dma_request == conversion_done_irq)
      else $error("dma request differs from interrupt");
   a_rdata_idle_zero: assert property (!bus_rd |=> bus_rdata == 8'h00)
      else $error("read data not zero without read");
   a_low_bits_zero: assert property (bus_rd && bus_addr[19:4] == 16'hFFFE && !bus_addr[3] && bus_addr[0]
      |=> bus_rdata[5:0] == 6'h00)
      else $error("result low byte spare bits not zero");
   a_trigger_ones: assert property (bus_rd && bus_addr == `ADC_ADDR_TRIGGER_CONTROL |=> bus_rdata[6:1] == 6'h3F)
      else $error("trigger control spare bits not one");
   a_irq_enable_off: assert property (bus_wr && bus_addr == `ADC_ADDR_CONTROL_STATUS && !bus_wdata[6]
      |-> ##2 !conversion_done_irq)
      else $error("interrupt with enable cleared");
   a_ack_clears_flag: assert property (dma_ack |-> ##3 !conversion_done_irq)
      else $error("dma activation left flag set");
   a_standby_clears: assert property (standby |=> !sample_start ##1 !conversion_done_irq)
      else $error("standby did not clear state");
endmodule

bind adc_sequencer adc_sequencer_properties u_props (.mclk(mclk), .rst(rst), .standby(standby),
   .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
   .sample_start(sample_start), .conversion_done_irq(conversion_done_irq), .dma_request(dma_request),
   .dma_ack(dma_ack));

`default_nettype wire

// ==== verif/analog_front_model.sv ====
// Analog front end model: a distinct result code for every input
`timescale 1ns/100ps
`default_nettype none

module analog_front_model
   import adc_pkg::*;
(
   // Converter side
   input wire logic mclk,
   input wire logic [2:0] analog_channel,
   output var sample_type analog_result
);
   always_ff @(posedge mclk) begin
      analog_result <= {analog_channel, 7'h2B ^ {4'h0, analog_channel}};
   end
endmodule

`default_nettype wire

// ==== verif/tb_adc_sequencer.sv ====
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adc_map.svh"

module tb_adc_sequencer
   import adc_pkg::*;
;
   localparam logic [19:0] CSR = `ADC_ADDR_CONTROL_STATUS;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic standby = 1'b0;
   logic bus_rd = 1'b0;
   logic bus_wr = 1'b0;
   logic ext = 1'b1;
   logic tmr = 1'b0;
   logic ack = 1'b0;
   logic rd_q = 1'b0;
   logic [19:0] addr = 20'h00000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   sample_type ares;
   logic [2:0] ach;
   logic ss, irq, dreq;
   logic [7:0] expq[$];
   logic [31:0] seed = 32'hAEA5824C;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;

   adc_sequencer u_dut (.mclk(mclk), .rst(rst), .ce(ce), .standby(standby), .bus_addr(addr), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_wdata(wdata), .bus_rdata(rdata), .external_trigger_pin(ext), .timer_compare_match(tmr),
      .analog_result(ares), .analog_channel(ach), .sample_start(ss), .conversion_done_irq(irq),
      .dma_request(dreq), .dma_ack(ack));
   analog_front_model u_afe (.mclk(mclk), .analog_channel(ach), .analog_result(ares));

   initial begin
      forever #10 mclk = ~mclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic sample_type res(input logic [2:0] c);
      return {c, 7'h2B ^ {4'h0, c}};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask

   // Expected read data is queued before the read is issued
   task automatic rd(input logic [19:0] a, input logic [7:0] e);
      expq.push_back(e);
      @(posedge mclk);
      addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
   endtask

   // Wait for the interrupt while the disabled start inputs see noise
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge mclk);
         seed = xs(seed);
         ext <= seed[0];
         tmr <= seed[1];
         n++;
      end
      check({7'h00, irq}, 8'h01);
   endtask

   task automatic chk_init();
      for (int i = 0; i < 10; i++) begin
         rd(20'(20'hFFFE0 + i), (i == 9) ? 8'h7E : 8'h00);
      end
      rd(20'hFFFEA, 8'h00);
   endtask

   always @(posedge mclk) begin
      if (rd_q) begin
         check(rdata, expq.pop_front());
      end
      rd_q <= bus_rd;
   end

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         end_sim();
      end
   end

   initial begin
      logic [7:0] cfg;
      sample_type r;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      chk_init();
      // Clock enable low drops a go write
      ce <= 1'b0;
      wr(CSR, 8'h20);
      ce <= 1'b1;
      rd(CSR, 8'h00);
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         wr(20'(20'hFFFE0 + i), seed[7:0]);
      end
      rd(20'hFFFE2, 8'h00);
      // Single mode over all eight inputs, both conversion times
      for (int c = 0; c < 8; c++) begin
         cfg = {4'h4, ~c[0], 3'(c)};
         r = res(3'(c));
         wr(CSR, cfg | 8'h20);
         wait_irq();
         wr(CSR, cfg);
         rd(CSR, cfg | 8'h80);
         wr(CSR, cfg);
         rd(CSR, cfg);
         rd(20'(20'hFFFE0 + 2 * (c % 4)), r[9:2]);
         rd(20'(20'hFFFE1 + 2 * (c % 4)), {r[1:0], 6'h00});
      end
      // Scan of three inputs in group zero, stopped by software
      wr(CSR, 8'h7A);
      wait_irq();
      rd(CSR, 8'hFA);
      wr(CSR, 8'hDA);
      rd(CSR, 8'hDA);
      @(posedge mclk) ack <= 1'b1;
      @(posedge mclk) ack <= 1'b0;
      rd(CSR, 8'h5A);
      for (int i = 0; i < 4; i++) begin
         r = res((i == 3) ? 3'd7 : 3'(i));
         rd(20'(20'hFFFE0 + 2 * i), r[9:2]);
      end
      // Timer match and falling pin edge with triggers enabled
      ext <= 1'b1;
      tmr <= 1'b0;
      wr(`ADC_ADDR_TRIGGER_CONTROL, 8'h80);
      rd(`ADC_ADDR_TRIGGER_CONTROL, 8'hFE);
      wr(CSR, 8'h0B);
      @(posedge mclk) tmr <= 1'b1;
      @(posedge mclk) tmr <= 1'b0;
      repeat (80) @(posedge mclk);
      rd(CSR, 8'h8B);
      wr(CSR, 8'h0D);
      @(posedge mclk) ext <= 1'b0;
      repeat (80) @(posedge mclk);
      rd(CSR, 8'h8D);
      r = res(3'd5);
      rd(20'hFFFE2, r[9:2]);
      // Abort mid conversion leaves flag and results alone
      wr(CSR, 8'h2C);
      repeat (10) @(posedge mclk);
      wr(CSR, 8'h0C);
      repeat (80) @(posedge mclk);
      rd(CSR, 8'h0C);
      r = res(3'd0);
      rd(20'hFFFE0, r[9:2]);
      // Standby during a conversion
      wr(CSR, 8'h2B);
      @(posedge mclk) standby <= 1'b1;
      @(posedge mclk) standby <= 1'b0;
      chk_init();
      repeat (3) @(posedge mclk);
      end_sim();
   end
endmodule

`default_nettype wire
